// ===== ssp_pkg.sv
// Constants shared by the serial port ends
//
// Summary of operation
// - Config bit 6 write enters/leaves power-down
// - Host rewrites other config bits unchanged on power-down entry
// - Host waits 32 clocks after power-down entry
// - Host never sends partial commands in power-down
// - Power-down writes change only bit 6
// - Host waits 50 ms after wake-up
// - Settings survive power-down untouched
// - Configuration register at address 1000000
// - Power-down releases LED and data pins
// - LED steady on motion, pulsed when idle
// - Host starts transfers and drives clock
// - Write: direction 1, address, data byte
// - Change on falling, sample on rising
// - Read: direction 0 address, device data
// - Host releases after address, device after data
// - Host allows 100 us before read data
// - Device holds last bit until next falling
// - Unmapped write ignored, read returns zero
// - Host waits 100 us after a write
// - Next command 250 ns after read end
// - Port resets on 90 ms transaction timeout outside power-down
// - Device drives after address, releases at end
// - Host drives idle data line after reset or a write, leaves it released after a read
package ssp_pkg;
  localparam logic [6:0] CFG_ADDR     = 7'h40;
  localparam int         PD_BIT       = 6;
  localparam logic [7:0] CFG_RESET    = 8'h00;
  localparam logic [4:0] ADDR_BITS    = 5'h08;
  localparam logic [4:0] XFER_BITS    = 5'h10;
  localparam int         CLK_KHZ      = 25000;
  localparam int         TMO_MS       = 90;
  localparam int         TMO_CYC_DEF  = TMO_MS * CLK_KHZ;
  localparam int         RD_PREP_US   = 100;
  localparam int         RD_PREP_CYC  = (RD_PREP_US * CLK_KHZ + 999) / 1000;
  localparam int         WR_GAP_US    = 100;
  localparam int         WR_GAP_CYC   = (WR_GAP_US * CLK_KHZ + 999) / 1000;
  localparam int         RD_GAP_NS    = 250;
  localparam int         RD_GAP_CYC   = (RD_GAP_NS * CLK_KHZ + 999999) / 1000000;
  localparam int         PD_SET_CYC   = 32;
  localparam int         WAKE_MS      = 50;
  localparam int         WAKE_CYC_DEF = WAKE_MS * CLK_KHZ;
  localparam int         HALF_DEF     = 4;
  localparam int         LED_PER_DEF  = 64;
  localparam int         LED_ON_DEF   = 8;
endpackage : ssp_pkg

// ===== ssp_if.sv
// Two-wire link between host and sensor port
`timescale 1ns/1ps
`default_nettype none
interface ssp_if;
  logic sclk;
  logic hostOut;
  logic hostOe;
  logic devOut;
  logic devOe;
  logic sdio;

  // Resolved data line, pulled high when nobody drives
  assign sdio = hostOe ? hostOut : (devOe ? devOut : 1'b1);

  modport host (output sclk, output hostOut, output hostOe, input sdio);
  modport device (input sclk, input sdio, output devOut, output devOe);
endinterface : ssp_if
`default_nettype wire

// ===== ssp_device.sv
// Sensor end of the serial port with power-down and LED control
`timescale 1ns/1ps
`default_nettype none
module ssp_device #(
  parameter int TMO_CYC    = ssp_pkg::TMO_CYC_DEF,
  parameter int LED_PERIOD = ssp_pkg::LED_PER_DEF,
  parameter int LED_ON     = ssp_pkg::LED_ON_DEF
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic motion,
  ssp_if.device     link,
  output logic      ledDriveOut,
  output logic      ledOe,
  output logic      powerDown
);
  import ssp_pkg::*;

  generate
    if (TMO_CYC < 1 || LED_PERIOD < 2 || LED_ON < 1 || LED_ON >= LED_PERIOD) begin : g_chk
      $error("ssp_device: bad parameter");
    end
  endgenerate

  // ****************************************
  // Link receive state, rising edges
  // ****************************************
  typedef struct packed {
    logic [4:0] cnt;
    logic       isRead;
    logic       busy;
    logic [6:0] addr;
    logic [7:0] shift;
    logic [7:0] rdData;
  } ssp_rx_s;

  typedef struct packed {
    logic [7:0] cfg;
  } ssp_cfg_s;

  typedef struct packed {
    logic oe;
    logic out;
  } ssp_tx_s;

  typedef struct packed {
    logic        busyS1;
    logic        busyS2;
    logic        pdS1;
    logic        pdS2;
    logic [31:0] tmoCnt;
    logic        tmo;
    logic [31:0] ledCnt;
    logic        led;
    logic        ledOe;
  } ssp_ck_s;

  ssp_rx_s  rx_q;
  ssp_rx_s  rx_d;
  ssp_cfg_s cfg_q;
  ssp_cfg_s cfg_d;
  ssp_tx_s  tx_q;
  ssp_tx_s  tx_d;
  ssp_ck_s  ck_q;
  ssp_ck_s  ck_d;
  logic     portRst;

  assign portRst = rst | ck_q.tmo;

  always_comb begin
    rx_d = rx_q;
    cfg_d = cfg_q;
    rx_d.shift = {rx_q.shift[6:0], link.sdio};
    if (rx_q.cnt == XFER_BITS - 5'h01) begin
      rx_d.cnt = 5'h00;
    end else begin
      rx_d.cnt = rx_q.cnt + 5'h01;
    end
    rx_d.busy = (rx_d.cnt != 5'h00);
    if (rx_q.cnt == 5'h00) begin
      rx_d.isRead = ~link.sdio;
    end
    if (rx_q.cnt == ADDR_BITS - 5'h01) begin
      rx_d.addr = rx_d.shift[6:0];
      if (rx_d.shift[6:0] == CFG_ADDR) begin
        rx_d.rdData = cfg_q.cfg;
      end else begin
        rx_d.rdData = 8'h00;
      end
    end
    if (rx_q.cnt == XFER_BITS - 5'h01 && !rx_q.isRead && rx_q.addr == CFG_ADDR) begin
      if (cfg_q.cfg[PD_BIT]) begin
        cfg_d.cfg[PD_BIT] = rx_d.shift[PD_BIT];
      end else begin
        cfg_d.cfg = rx_d.shift;
      end
    end
  end

  always_ff @(posedge link.sclk or posedge portRst) begin
    if (portRst) begin
      rx_q <= '0;
    end else begin
      rx_q <= rx_d;
    end
  end

  // ****************************************
  // Configuration storage, kept across port resets
  // ****************************************
  always_ff @(posedge link.sclk or posedge rst) begin
    if (rst) begin
      cfg_q <= '{cfg: CFG_RESET};
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // ****************************************
  // Link transmit state, falling edges
  // ****************************************
  always_comb begin
    tx_d = tx_q;
    if (rx_q.isRead && rx_q.cnt >= ADDR_BITS && !cfg_q.cfg[PD_BIT]) begin
      tx_d.oe = 1'b1;
      tx_d.out = rx_q.rdData[~rx_q.cnt[2:0]];
    end else begin
      tx_d.oe = 1'b0;
    end
  end

  always_ff @(negedge link.sclk or posedge portRst) begin
    if (portRst) begin
      tx_q <= '0;
    end else begin
      tx_q <= tx_d;
    end
  end

  // Device only answers, never starts a transfer
  assign link.devOut = tx_q.out;
  assign link.devOe = tx_q.oe & ~cfg_q.cfg[PD_BIT];

  // ****************************************
  // Oscillator domain: timeout and LED
  // ****************************************
  always_comb begin
    ck_d = ck_q;
    ck_d.busyS1 = rx_q.busy;
    ck_d.busyS2 = ck_q.busyS1;
    ck_d.pdS1 = cfg_q.cfg[PD_BIT];
    ck_d.pdS2 = ck_q.pdS1;
    if (!ck_q.busyS2 || ck_q.pdS2) begin
      ck_d.tmoCnt = 32'h0;
      if (!ck_q.busyS2) begin
        ck_d.tmo = 1'b0;
      end
    end else if (ck_q.tmoCnt >= 32'(TMO_CYC - 1)) begin
      ck_d.tmo = 1'b1;
    end else begin
      ck_d.tmoCnt = ck_q.tmoCnt + 32'h1;
    end
    if (ck_q.ledCnt >= 32'(LED_PERIOD - 1)) begin
      ck_d.ledCnt = 32'h0;
    end else begin
      ck_d.ledCnt = ck_q.ledCnt + 32'h1;
    end
    if (ck_q.pdS2) begin
      ck_d.led = 1'b0;
    end else if (motion) begin
      ck_d.led = 1'b1;
    end else begin
      ck_d.led = (ck_q.ledCnt < 32'(LED_ON));
    end
    ck_d.ledOe = ~ck_q.pdS2;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ck_q <= '0;
    end else begin
      ck_q <= ck_d;
    end
  end

  assign ledDriveOut = ck_q.led;
  assign ledOe = ck_q.ledOe;
  assign powerDown = ck_q.pdS2;
endmodule : ssp_device
`default_nettype wire

// ===== ssp_host.sv
// Host end of the serial port, making the link clock
`timescale 1ns/1ps
`default_nettype none
module ssp_host #(
  parameter int HALF     = ssp_pkg::HALF_DEF,
  parameter int WAKE_CYC = ssp_pkg::WAKE_CYC_DEF
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire logic       writeEn,
  input  wire logic [6:0] addr,
  input  wire logic [7:0] wdata,
  ssp_if.host             link,
  output logic            busy,
  output logic            done,
  output logic [7:0]      rdata
);
  import ssp_pkg::*;

  generate
    if (HALF < 3 || WAKE_CYC < 1 || WAKE_CYC > 2000000 || PD_SET_CYC > WR_GAP_CYC)
    begin : g_chk
      $error("ssp_host: bad parameter");
    end
  endgenerate

  typedef enum logic [4:0] {
    SSP_IDLE = 5'h01,
    SSP_LOW  = 5'h02,
    SSP_HIGH = 5'h04,
    SSP_TURN = 5'h08,
    SSP_GAP  = 5'h10
  } ssp_st_e;

  typedef struct packed {
    ssp_st_e     st;
    logic [20:0] cnt;
    logic [20:0] gap;
    logic [4:0]  bitIdx;
    logic [15:0] shift;
    logic        isRd;
    logic        sclk;
    logic        sdo;
    logic        oe;
    logic        s1;
    logic        s2;
    logic        busy;
    logic        done;
    logic [7:0]  rdata;
    logic [7:0]  shadow;
  } ssp_hst_s;

  ssp_hst_s q;
  ssp_hst_s d;

  // ****************************************
  // Transfer sequencer
  // ****************************************
  always_comb begin
    logic [7:0] dat;
    dat = wdata;
    d = q;
    d.done = 1'b0;
    d.s1 = link.sdio;
    d.s2 = q.s1;
    case (q.st)
      SSP_IDLE: begin
        if (start) begin
          if (writeEn && addr == CFG_ADDR && wdata[PD_BIT]) begin
            dat = {q.shadow[7], 1'b1, q.shadow[5:0]};
          end
          d.shift = {writeEn, addr, dat};
          d.isRd = ~writeEn;
          d.busy = 1'b1;
          d.bitIdx = 5'h00;
          d.cnt = 21'h0;
          d.st = SSP_LOW;
          d.sclk = 1'b0;
          d.oe = 1'b1;
          d.sdo = writeEn;
          if (!writeEn) begin
            d.gap = 21'(RD_GAP_CYC);
          end else if (addr == CFG_ADDR && q.shadow[PD_BIT] && !dat[PD_BIT]) begin
            d.gap = 21'(WAKE_CYC);
          end else begin
            d.gap = 21'(WR_GAP_CYC);
          end
          if (writeEn && addr == CFG_ADDR) begin
            if (q.shadow[PD_BIT]) begin
              d.shadow[PD_BIT] = dat[PD_BIT];
            end else begin
              d.shadow = dat;
            end
          end
        end
      end
      SSP_LOW: begin
        if (q.cnt == 21'(HALF - 1)) begin
          d.cnt = 21'h0;
          d.sclk = 1'b1;
          d.st = SSP_HIGH;
        end else begin
          d.cnt = q.cnt + 21'h1;
        end
      end
      SSP_HIGH: begin
        if (q.cnt == 21'(HALF - 1)) begin
          d.cnt = 21'h0;
          d.bitIdx = q.bitIdx + 5'h01;
          if (q.isRd && q.bitIdx >= ADDR_BITS) begin
            d.rdata = {q.rdata[6:0], q.s2};
          end
          if (q.bitIdx == XFER_BITS - 5'h01) begin
            d.st = SSP_GAP;
            if (!q.isRd) begin
              d.oe = 1'b1;
              d.sdo = 1'b1;
            end
          end else if (q.isRd && q.bitIdx == ADDR_BITS - 5'h01) begin
            d.st = SSP_TURN;
            d.oe = 1'b0;
          end else begin
            d.st = SSP_LOW;
            d.sclk = 1'b0;
            d.shift = {q.shift[14:0], 1'b0};
            d.sdo = q.shift[14];
          end
        end else begin
          d.cnt = q.cnt + 21'h1;
        end
      end
      SSP_TURN: begin
        if (q.cnt == 21'(RD_PREP_CYC - 1)) begin
          d.cnt = 21'h0;
          d.st = SSP_LOW;
          d.sclk = 1'b0;
        end else begin
          d.cnt = q.cnt + 21'h1;
        end
      end
      SSP_GAP: begin
        if (q.cnt >= q.gap - 21'h1) begin
          d.cnt = 21'h0;
          d.st = SSP_IDLE;
          d.busy = 1'b0;
          d.done = 1'b1;
        end else begin
          d.cnt = q.cnt + 21'h1;
        end
      end
      default: begin
        d.st = SSP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '{st: SSP_IDLE, sclk: 1'b1, sdo: 1'b1, oe: 1'b1, shadow: CFG_RESET,
             default: '0};
    end else begin
      q <= d;
    end
  end

  assign link.sclk = q.sclk;
  assign link.hostOut = q.sdo;
  assign link.hostOe = q.oe;
  assign busy = q.busy;
  assign done = q.done;
  assign rdata = q.rdata;
endmodule : ssp_host
`default_nettype wire

// ===== ssp_chk.sv
// Checker for the two-wire link signals
`timescale 1ns/1ps
`default_nettype none
module ssp_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic hostOut,
  input wire logic hostOe,
  input wire logic devOut,
  input wire logic devOe,
  input wire logic sdio
);
  import ssp_pkg::*;
  // ****************
  // Helper logic
  // ****************
  int   hiCnt;
  int   relFalls;
  logic sclkQ;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hiCnt <= 0;
      relFalls <= 0;
      sclkQ <= 1'b1;
    end else begin
      hiCnt <= sclk ? hiCnt + 1 : 0;
      sclkQ <= sclk;
      if (hostOe) begin
        relFalls <= 0;
      end else if (sclkQ && !sclk) begin
        relFalls <= relFalls + 1;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ****************
  // Properties
  // ****************
  sequence s_highHeld; devOe && sclk ##1 sclk; endsequence
  sequence s_firstDataFall; $fell(sclk) && !hostOe && relFalls == 0; endsequence
  property p_noFight; !(hostOe && devOe); endproperty
  property p_sampleStable; $rose(sclk) |-> $stable(sdio); endproperty
  property p_driveOnFall; $rose(devOe) |-> !sclk; endproperty
  property p_releaseOnFall; $fell(devOe) |-> !sclk; endproperty
  property p_holdLast; s_highHeld |-> devOe; endproperty
  property p_turnaround; $rose(devOe) |-> !$past(hostOe, 2); endproperty
  property p_prepTime; s_firstDataFall |-> hiCnt >= RD_PREP_CYC; endproperty
  property p_devStable; devOe && $past(devOe) && sclk |-> $stable(devOut); endproperty
  a_noFight: assert property (p_noFight)
    else $error("both ends drive the data line");
  a_sampleStable: assert property (p_sampleStable)
    else $error("data changed at a rising clock");
  a_driveOnFall: assert property (p_driveOnFall)
    else $error("device drive began off a falling clock");
  a_releaseOnFall: assert property (p_releaseOnFall)
    else $error("device release off a falling clock");
  a_holdLast: assert property (p_holdLast)
    else $error("device dropped data while clock high");
  a_turnaround: assert property (p_turnaround)
    else $error("device drove before host release");
  a_prepTime: assert property (p_prepTime)
    else $error("read data clocked too early");
  a_devStable: assert property (p_devStable)
    else $error("device data changed while clock high");
endmodule : ssp_chk
`default_nettype wire

// ===== tb_sensor_serial_port_pd.sv
// Testbench joining host and sensor ends of the link
`timescale 1ns/1ps
`default_nettype none
module tb_sensor_serial_port_pd;
  import ssp_pkg::*;
  logic        clk = 1'b0;
  logic        dclk = 1'b0;
  logic        rst = 1'b0;
  logic        start = 1'b0;
  logic        writeEn = 1'b0;
  logic        motion = 1'b0;
  logic [6:0]  addr = 7'h00;
  logic [7:0]  wdata = 8'h00;
  logic        busy, done, ledDriveOut, ledOe, powerDown;
  logic [7:0]  rdata;
  logic [15:0] wireBits = 16'h0000;
  int          badCount = 0;
  int          comparisons = 0;
  ssp_if link ();
  ssp_host #(.HALF(HALF_DEF), .WAKE_CYC(100)) u_ssp_host (.clk(clk), .rst(rst),
    .start(start), .writeEn(writeEn), .addr(addr), .wdata(wdata), .link(link),
    .busy(busy), .done(done), .rdata(rdata));
  ssp_device #(.TMO_CYC(4000)) u_ssp_device (.clk(dclk), .rst(rst), .motion(motion),
    .link(link), .ledDriveOut(ledDriveOut), .ledOe(ledOe), .powerDown(powerDown));
  ssp_chk u_ssp_chk (.clk(clk), .rst(rst), .sclk(link.sclk), .hostOut(link.hostOut),
    .hostOe(link.hostOe), .devOut(link.devOut), .devOe(link.devOe), .sdio(link.sdio));
  always #20 clk = ~clk;
  always #24 dclk = ~dclk;
  always @(posedge link.sclk) wireBits <= {wireBits[14:0], link.sdio};
  // ****************
  // Shared tasks
  // ****************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      badCount++;
    end
  endtask : check
  task automatic results;
    $display("mismatches %0d comparisons %0d", badCount, comparisons);
    if (badCount == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results
  task automatic xfer(input logic we, input logic [6:0] a, input logic [7:0] d);
    int n;
    @(negedge clk);
    start = 1'b1; writeEn = we; addr = a; wdata = d;
    @(negedge clk);
    start = 1'b0;
    check(16'(busy), 16'h0001);
    n = 0;
    while (done !== 1'b1 && n < 10000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 10000) begin
      badCount++;
      results();
    end
    check(16'(busy), 16'h0000);
  endtask : xfer
  // ****************
  // Scenarios
  // ****************
  task automatic t_writeRead;
    check(16'(ledOe), 16'h0001);
    xfer(1'b1, CFG_ADDR, 8'h05);
    check(wireBits, {1'b1, CFG_ADDR, 8'h05});
    xfer(1'b0, CFG_ADDR, 8'h00);
    check(16'(rdata), 16'h0005);
    check(wireBits, {1'b0, CFG_ADDR, 8'h05});
  endtask : t_writeRead
  task automatic t_unmapped;
    xfer(1'b1, 7'h77, 8'h5a);
    xfer(1'b0, 7'h77, 8'h00);
    check(16'(rdata), 16'h0000);
    xfer(1'b0, CFG_ADDR, 8'h00);
    check(16'(rdata), 16'h0005);
  endtask : t_unmapped
  task automatic t_powerDown;
    xfer(1'b1, CFG_ADDR, 8'h40);
    check(wireBits, {1'b1, CFG_ADDR, 8'h45});
    check(16'(powerDown), 16'h0001);
    check(16'(ledOe), 16'h0000);
    xfer(1'b0, CFG_ADDR, 8'h00);
    check(16'(rdata), 16'h00ff);
    xfer(1'b1, CFG_ADDR, 8'h00);
    check(16'(powerDown), 16'h0000);
    xfer(1'b0, CFG_ADDR, 8'h00);
    check(16'(rdata), 16'h0005);
    check(16'(ledOe), 16'h0001);
  endtask : t_powerDown
  task automatic t_led;
    int n;
    @(negedge dclk);
    motion = 1'b1;
    repeat (3) @(negedge dclk);
    n = 0;
    repeat (16) begin
      @(negedge dclk);
      n += int'(ledDriveOut === 1'b1);
    end
    check(16'(n), 16'd16);
    motion = 1'b0;
    repeat (3) @(negedge dclk);
    n = 0;
    repeat (LED_PER_DEF) begin
      @(negedge dclk);
      n += int'(ledDriveOut === 1'b1);
    end
    check(16'(n), 16'(LED_ON_DEF));
  endtask : t_led
  initial begin
    #1;
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    t_writeRead();
    t_unmapped();
    t_powerDown();
    t_led();
    results();
  end
endmodule : tb_sensor_serial_port_pd
`default_nettype wire
